// >>> design/switch_core_lookup_mac.sv
/*
 * Switch core: address table with learning, migration and aging, forwarding,
 * buffer accounting, flow control, storm protection and per-port MAC timing.
 * Assumes ingress MACs present one descriptor per complete frame and the
 * queue logic moves frame data; carrier and collision pins are asynchronous.
 */
// The register addresses and the Wishbone slave port were decided locally.
// Behaviour
// - 1K-entry associative table of 48-bit addresses
// - Learn unknown source of good frames
// - Table full: replace last entry
// - Known source on new port: update port
// - Refresh stamp; age out after 300 s
// - Aging enabled by reset strap
// - Hit sends to stored port; local discarded
// - Miss or multicast floods except ingress
// - Never forward errored or illegal frames
// - Pause frames consumed locally
// - Forward only after frame fully received
// - 1024 shared buffers of 128 bytes
// - Strap selects fixed 113 or adaptive 512
// - 96 bit-time gap, after collision from carrier
// - Exponential backoff, aggressive option, drop after 16
// - Late collision abandons frame
// - Runts dropped; 1536 bytes when programmed
// - Pause holds normal frames until timer expires
// - XOFF on exhausted destination, XON with hysteresis
// - Half duplex back pressure with carrier
// - Collision under back pressure skips backoff
// - Broadcast storm limit per period
`timescale 1ns/1ps
`default_nettype none
module switch_core_lookup_mac #(
	parameter longint unsigned AGE_EPOCH_CYCLES = switch_core_pkg::AGE_EPOCH_CYCLES,
	parameter int unsigned     STORM_CYCLES     = switch_core_pkg::STORM_CYCLES
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [31:0] adr_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]      dat_o,
	input  wire logic [3:0]  sel_i,
	input  wire logic        we_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	output logic             ack_o,
	input  wire logic        aging_strap_i,
	input  wire logic        buffer_mode_strap_i,
	input  wire logic        frm_valid_i,
	output logic             frm_ready_o,
	input  wire logic [3:0]  frm_port_i,
	input  wire logic [47:0] frm_sa_i,
	input  wire logic [47:0] frm_da_i,
	input  wire logic [10:0] frm_len_i,
	input  wire logic        frm_err_i,
	input  wire logic        frm_vlan_i,
	input  wire logic        frm_pause_i,
	input  wire logic [15:0] frm_pause_time_i,
	output logic             fwd_valid_o,
	output logic [8:0]       fwd_mask_o,
	output logic             fwd_discard_o,
	input  wire logic [8:0]  buf_alloc_i,
	input  wire logic [8:0]  buf_free_i,
	output logic [8:0]       buf_grant_o,
	input  wire logic        rxq_full_i,
	output logic [8:0]       pause_xoff_o,
	output logic [8:0]       pause_xon_o,
	input  wire logic [8:0]  full_duplex_i,
	input  wire logic [8:0]  speed_10_i,
	input  wire logic [8:0]  tx_frame_req_i,
	input  wire logic [8:0]  tx_ctrl_req_i,
	input  wire logic [8:0]  tx_last_i,
	input  wire logic [8:0]  mii_carrier_sense_i,
	input  wire logic [8:0]  mii_col_i,
	output logic [8:0]       mii_tx_enable_o,
	output logic [8:0]       tx_done_o,
	output logic [8:0]       tx_abort_o,
	output logic [8:0]       bp_active_o
);
	localparam logic [8:0] ALL = 9'h1ff;

	// Synchronisers and straps
	logic [8:0] crs_s1, crs_s2, col_s1, col_s2;
	logic       age_s1, age_s2, bm_s1, bm_s2, aging_en_reg, bmode_reg;
	always_ff @(posedge clk_i) begin
		crs_s1 <= mii_carrier_sense_i;
		crs_s2 <= crs_s1;
		col_s1 <= mii_col_i;
		col_s2 <= col_s1;
		age_s1 <= aging_strap_i;
		age_s2 <= age_s1;
		bm_s1  <= buffer_mode_strap_i;
		bm_s2  <= bm_s1;
		// strap caught while reset is held
		if (rst_i) begin
			aging_en_reg <= age_s2;
			bmode_reg    <= bm_s2;
		end
	end

	// Wishbone slave, one wait state
	logic [4:0]  ctrl_reg, ctrl_next;
	logic        ack_reg;
	logic [31:0] dat_reg, dat_next;
	logic [10:0] ent_cnt_reg;
	logic [8:0]  fc_act;
	always_comb begin
		ctrl_next = ctrl_reg;
		dat_next  = 32'h0;
		if (cyc_i && stb_i && !ack_reg) begin
			if (adr_i == switch_core_pkg::REG_CTRL) begin
				dat_next = {27'h0, ctrl_reg};
				if (we_i && sel_i[0])
					ctrl_next = dat_i[4:0];
			end else if (adr_i == switch_core_pkg::REG_STATUS) begin
				dat_next = {3'h0, fc_act, 2'h0, bmode_reg, aging_en_reg, 5'h0, ent_cnt_reg};
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= switch_core_pkg::CTRL_RST;
			ack_reg  <= 1'b0;
			dat_reg  <= 32'h0;
		end else begin
			ctrl_reg <= ctrl_next;
			ack_reg  <= cyc_i && stb_i && !ack_reg;
			dat_reg  <= dat_next;
		end
	end
	assign ack_o = ack_reg;
	assign dat_o = dat_reg;

	logic [switch_core_pkg::ENT_W-1:0] tbl [switch_core_pkg::TBL_DEPTH];
	logic [switch_core_pkg::ENT_W-1:0] ent, mem_wd;
	logic [9:0] mem_wa;
	logic       mem_we;
	switch_core_pkg::lk_state_type lk_reg, lk_next;
	logic [9:0]  idx_reg, idx_next, sa_idx_reg, sa_idx_next, free_reg, free_next;
	logic [9:0]  age_ptr_reg, age_ptr_next;
	logic        sa_hit_reg, sa_hit_next, da_hit_reg, da_hit_next, free_ok_reg, free_ok_next;
	logic [3:0]  da_port_reg, da_port_next, port_reg, port_next;
	logic [47:0] sa_reg, sa_next, da_reg, da_next;
	logic [1:0]  epoch_reg, epoch_next;
	logic [32:0] age_cnt_reg, age_cnt_next;
	logic [10:0] ent_cnt_next;
	logic        fwd_v_next, disc_next;
	logic [8:0]  mask_next, pload_reg, pload_next, bc_seen;
	logic [15:0] pval_reg, pval_next;
	logic [8:0]  storm_over;
	logic [10:0] max_len;
	logic        bad, bcast;
	always_comb begin
		ent          = tbl[lk_reg == switch_core_pkg::LK_SCAN ? idx_reg : age_ptr_reg];
		lk_next      = lk_reg;
		idx_next     = idx_reg;
		sa_idx_next  = sa_idx_reg;
		free_next    = free_reg;
		age_ptr_next = age_ptr_reg;
		sa_hit_next  = sa_hit_reg;
		da_hit_next  = da_hit_reg;
		free_ok_next = free_ok_reg;
		da_port_next = da_port_reg;
		port_next    = port_reg;
		sa_next      = sa_reg;
		da_next      = da_reg;
		ent_cnt_next = ent_cnt_reg;
		fwd_v_next   = 1'b0;
		disc_next    = 1'b0;
		mask_next    = fwd_mask_o;
		pload_next   = 9'h0;
		pval_next    = pval_reg;
		bc_seen      = 9'h0;
		mem_we       = 1'b0;
		mem_wa       = age_ptr_reg;
		mem_wd       = '0;
		// epoch advances every half aging period
		epoch_next   = epoch_reg;
		age_cnt_next = age_cnt_reg + 33'd1;
		if (age_cnt_reg >= 33'(AGE_EPOCH_CYCLES - 1)) begin
			age_cnt_next = 33'h0;
			epoch_next   = epoch_reg + 2'd1;
		end
		// length limits, longer with tag or when programmed
		if (ctrl_reg[switch_core_pkg::CTRL_LONG])
			max_len = switch_core_pkg::MAX_LEN_LONG;
		else if (frm_vlan_i)
			max_len = switch_core_pkg::MAX_LEN_VLAN;
		else
			max_len = switch_core_pkg::MAX_LEN;
		bcast = &frm_da_i;
		// errored and illegal-size frames are never forwarded
		bad = frm_err_i || frm_len_i < switch_core_pkg::MIN_LEN || frm_len_i > max_len;
		case (lk_reg)
			switch_core_pkg::LK_IDLE: begin
				// decision only on a complete-frame descriptor
				if (frm_valid_i) begin
					if (bad) begin
						disc_next = 1'b1;
					end else if (frm_pause_i) begin
						// pause frame acted on, not forwarded
						disc_next  = 1'b1;
						pload_next = 9'(1) << frm_port_i;
						pval_next  = frm_pause_time_i;
					end else if (bcast && storm_over[frm_port_i]) begin
						// broadcast over the window limit dropped
						disc_next = 1'b1;
					end else begin
						bc_seen      = bcast ? 9'(1) << frm_port_i : 9'h0;
						port_next    = frm_port_i;
						sa_next      = frm_sa_i;
						da_next      = frm_da_i;
						idx_next     = 10'h0;
						sa_hit_next  = 1'b0;
						da_hit_next  = 1'b0;
						free_ok_next = 1'b0;
						lk_next      = switch_core_pkg::LK_SCAN;
					end
				end else if (aging_en_reg) begin
					// only when the strap enabled aging
					age_ptr_next = age_ptr_reg + 10'd1;
					if (ent[switch_core_pkg::ENT_VALID_BIT] &&
					    (epoch_reg - ent[switch_core_pkg::ENT_STAMP_LSB +: 2]) >= 2'd3) begin
						mem_we       = 1'b1;
						ent_cnt_next = ent_cnt_reg - 11'd1;
					end
				end
			end
			switch_core_pkg::LK_SCAN: begin
				idx_next = idx_reg + 10'd1;
				if (ent[switch_core_pkg::ENT_VALID_BIT]) begin
					if (ent[47:0] == sa_reg) begin
						sa_hit_next = 1'b1;
						sa_idx_next = idx_reg;
					end
					if (ent[47:0] == da_reg) begin
						da_hit_next  = 1'b1;
						da_port_next = ent[switch_core_pkg::ENT_PORT_LSB +: 4];
					end
				end else if (!free_ok_reg) begin
					free_ok_next = 1'b1;
					free_next    = idx_reg;
				end
				if (idx_reg == 10'(switch_core_pkg::TBL_DEPTH - 1))
					lk_next = switch_core_pkg::LK_WRITE;
			end
			default: begin
				lk_next = switch_core_pkg::LK_IDLE;
				mem_we  = 1'b1;
				mem_wd  = {1'b1, epoch_reg, port_reg, sa_reg};
				if (sa_hit_reg) begin
					mem_wa = sa_idx_reg;
				end else if (free_ok_reg) begin
					mem_wa       = free_reg;
					ent_cnt_next = ent_cnt_reg + 11'd1;
				end else begin
					// full table overwrites the last entry
					mem_wa = 10'(switch_core_pkg::TBL_DEPTH - 1);
				end
				fwd_v_next = 1'b1;
				if (da_reg[40] || !da_hit_reg) begin
					mask_next = ALL & ~(9'(1) << port_reg);
				end else if (da_port_reg == port_reg) begin
					mask_next  = 9'h0;
					fwd_v_next = 1'b0;
					disc_next  = 1'b1;
				end else begin
					mask_next = 9'(1) << da_port_reg;
				end
			end
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (mem_we)
			tbl[mem_wa] <= mem_wd;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lk_reg      <= switch_core_pkg::LK_IDLE;
			idx_reg     <= 10'h0;
			sa_idx_reg  <= 10'h0;
			free_reg    <= 10'h0;
			age_ptr_reg <= 10'h0;
			sa_hit_reg  <= 1'b0;
			da_hit_reg  <= 1'b0;
			free_ok_reg <= 1'b0;
			da_port_reg <= 4'h0;
			port_reg    <= 4'h0;
			sa_reg      <= 48'h0;
			da_reg      <= 48'h0;
			epoch_reg   <= 2'h0;
			age_cnt_reg <= 33'h0;
			ent_cnt_reg <= 11'h0;
			fwd_valid_o <= 1'b0;
			fwd_discard_o <= 1'b0;
			fwd_mask_o  <= 9'h0;
			pload_reg   <= 9'h0;
			pval_reg    <= 16'h0;
		end else begin
			lk_reg      <= lk_next;
			idx_reg     <= idx_next;
			sa_idx_reg  <= sa_idx_next;
			free_reg    <= free_next;
			age_ptr_reg <= age_ptr_next;
			sa_hit_reg  <= sa_hit_next;
			da_hit_reg  <= da_hit_next;
			free_ok_reg <= free_ok_next;
			da_port_reg <= da_port_next;
			port_reg    <= port_next;
			sa_reg      <= sa_next;
			da_reg      <= da_next;
			epoch_reg   <= epoch_next;
			age_cnt_reg <= age_cnt_next;
			ent_cnt_reg <= ent_cnt_next;
			fwd_valid_o <= fwd_v_next;
			fwd_discard_o <= disc_next;
			fwd_mask_o  <= mask_next;
			pload_reg   <= pload_next;
			pval_reg    <= pval_next;
		end
	end
	assign frm_ready_o = (lk_reg == switch_core_pkg::LK_IDLE);

	// Storm window and shared backoff random source
	logic [31:0] storm_cnt_reg, storm_cnt_next;
	logic [15:0] lfsr_reg, lfsr_next;
	logic        storm_end;
	logic [10:0] buf_total;
	logic [8:0]  buf_freed;
	logic [9:0]  bcnt_all [switch_core_pkg::PORTS];
	logic [9:0]  lim_all [switch_core_pkg::PORTS];
	always_comb begin
		storm_end      = storm_cnt_reg >= STORM_CYCLES - 1;
		storm_cnt_next = storm_end ? 32'h0 : storm_cnt_reg + 32'h1;
		lfsr_next      = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			storm_cnt_reg <= 32'h0;
			lfsr_reg      <= 16'hace1;
		end else begin
			storm_cnt_reg <= storm_cnt_next;
			lfsr_reg      <= lfsr_next;
		end
	end

	for (genvar p = 0; p < switch_core_pkg::PORTS; p++) begin : g_port
		logic [9:0]  bcnt_reg, bcnt_next, lim;
		logic [7:0]  bc_reg, bc_next;
		logic        fc_reg, fc_next;
		logic [8:0]  dst_reg, dst_next;
		switch_core_pkg::tx_state_type st_reg, st_next;
		logic [11:0] cnt_reg, cnt_next, gap_reg, gap_next, ipg, slot;
		logic [9:0]  bo_reg, bo_next, bo_mask;
		logic [4:0]  att_reg, att_next, k;
		logic [15:0] pause_reg, pause_next;
		logic [11:0] q_reg, q_next;
		logic        ac_reg, ac_next, en_next, done_next, abort_next, want, bp_req;
		always_comb begin
			// per-port share of the 1024 buffers
			// fixed 113 or adaptive up to 512
			lim = bmode_reg ? switch_core_pkg::BUF_ADAPT : switch_core_pkg::BUF_FIXED;
			buf_grant_o[p] = buf_alloc_i[p] && bcnt_reg < lim &&
			                 buf_total <= switch_core_pkg::BUF_TOTAL - 11'd9;
			bcnt_next = bcnt_reg + 10'(buf_grant_o[p]) - 10'(buf_free_i[p] && bcnt_reg != 10'h0);
			buf_freed[p] = bcnt_reg + switch_core_pkg::FC_LO < lim;
			bc_next = storm_end ? 8'h0 : bc_reg + 8'(bc_seen[p]);
			storm_over[p] = ctrl_reg[switch_core_pkg::CTRL_STORM] &&
			                bc_reg >= switch_core_pkg::STORM_LIMIT;
			// exhausted destinations pause this ingress, release at low mark
			dst_next = dst_reg;
			fc_next  = fc_reg;
			// Release first, so a new exhaustion in the same cycle wins
			if (fc_reg && (dst_reg & ~buf_freed) == 9'h0)
				dst_next = 9'h0;
			if (fwd_valid_o && port_reg == 4'(p)) begin
				for (int d = 0; d < 9; d++) begin
					if (fwd_mask_o[d] && bcnt_all[d] + switch_core_pkg::FC_HI >= lim_all[d])
						dst_next[d] = 1'b1;
				end
			end
			if (|dst_next)
				fc_next = 1'b1;
			else if (fc_reg && !rxq_full_i && (dst_reg & ~buf_freed) == 9'h0)
				fc_next = 1'b0;
			if (rxq_full_i)
				fc_next = 1'b1;
			ipg  = speed_10_i[p] ? 12'(switch_core_pkg::IPG_CYC * 10) : switch_core_pkg::IPG_CYC;
			slot = speed_10_i[p] ? 12'(switch_core_pkg::SLOT_CYC * 10) : switch_core_pkg::SLOT_CYC;
			// normal frames held while paused, control frames pass
			want   = tx_ctrl_req_i[p] || (tx_frame_req_i[p] && pause_reg == 16'h0);
			bp_req = fc_reg && !full_duplex_i[p] && ctrl_reg[switch_core_pkg::CTRL_BP];
			// timer loaded or reloaded by each pause frame
			pause_next = pause_reg;
			q_next     = q_reg;
			if (pload_reg[p]) begin
				pause_next = pval_reg;
				q_next     = 12'h0;
			end else if (pause_reg != 16'h0) begin
				q_next = q_reg + 12'h1;
				if (q_reg >= slot - 12'h1) begin
					q_next     = 12'h0;
					pause_next = pause_reg - 16'h1;
				end
			end
			// gap restarts on enable, or on carrier after a collision
			ac_next  = ac_reg && crs_s2[p];
			gap_next = (mii_tx_enable_o[p] || (ac_reg && crs_s2[p])) ? 12'h0 :
			           (gap_reg == 12'hfff ? gap_reg : gap_reg + 12'h1);
			st_next    = st_reg;
			cnt_next   = cnt_reg + 12'h1;
			bo_next    = bo_reg;
			att_next   = att_reg;
			done_next  = 1'b0;
			abort_next = 1'b0;
			k = ctrl_reg[switch_core_pkg::CTRL_AGGR] ? switch_core_pkg::AGGR_LIMIT :
			    switch_core_pkg::BACKOFF_LIMIT;
			k = (att_reg + 5'd1 < k) ? att_reg + 5'd1 : k;
			bo_mask = 10'((11'h1 << k) - 11'h1);
			case (st_reg)
				switch_core_pkg::TX_IDLE: begin
					cnt_next = 12'h0;
					// start only after the full gap
					if (want && gap_reg >= ipg)
						st_next = switch_core_pkg::TX_SEND;
					else if (!want && bp_req)
						st_next = switch_core_pkg::TX_BP_ON;
				end
				switch_core_pkg::TX_SEND: begin
					if (col_s2[p] && !full_duplex_i[p]) begin
						ac_next  = 1'b1;
						cnt_next = 12'h0;
						if (cnt_reg >= slot) begin
							abort_next = 1'b1;
							att_next   = 5'h0;
							st_next    = switch_core_pkg::TX_IDLE;
						end else if (bp_req) begin
							// no backoff, carrier back at once
							st_next = switch_core_pkg::TX_BP_ON;
						end else if (att_reg == switch_core_pkg::ATTEMPT_LAST &&
						             ctrl_reg[switch_core_pkg::CTRL_DROP16]) begin
							abort_next = 1'b1;
							att_next   = 5'h0;
							st_next    = switch_core_pkg::TX_IDLE;
						end else begin
							// random slots, range doubles per attempt
							att_next = (att_reg == switch_core_pkg::ATTEMPT_LAST) ?
							           att_reg : att_reg + 5'd1;
							bo_next  = lfsr_reg[9:0] & bo_mask;
							st_next  = switch_core_pkg::TX_WAIT;
						end
					end else if (tx_last_i[p]) begin
						done_next = 1'b1;
						att_next  = 5'h0;
						st_next   = switch_core_pkg::TX_IDLE;
					end
				end
				switch_core_pkg::TX_WAIT: begin
					if (bo_reg == 10'h0) begin
						st_next = switch_core_pkg::TX_IDLE;
					end else if (cnt_reg >= slot - 12'h1) begin
						cnt_next = 12'h0;
						bo_next  = bo_reg - 10'h1;
					end
				end
				switch_core_pkg::TX_BP_ON: begin
					// carrier held, yields to queued frames
					if (want || !bp_req)
						st_next = switch_core_pkg::TX_IDLE;
					else if (cnt_reg >= switch_core_pkg::BP_ON_CYC - 12'h1) begin
						cnt_next = 12'h0;
						st_next  = switch_core_pkg::TX_BP_OFF;
					end
				end
				default: begin
					// short silent gap, then carrier again
					if (want || !bp_req)
						st_next = switch_core_pkg::TX_IDLE;
					else if (cnt_reg >= switch_core_pkg::BP_OFF_CYC - 12'h1) begin
						cnt_next = 12'h0;
						st_next  = switch_core_pkg::TX_BP_ON;
					end
				end
			endcase
			en_next = (st_next == switch_core_pkg::TX_SEND) || (st_next == switch_core_pkg::TX_BP_ON);
		end
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				bcnt_reg  <= 10'h0;
				bc_reg    <= 8'h0;
				fc_reg    <= 1'b0;
				dst_reg   <= 9'h0;
				st_reg    <= switch_core_pkg::TX_IDLE;
				cnt_reg   <= 12'h0;
				gap_reg   <= 12'hfff;
				bo_reg    <= 10'h0;
				att_reg   <= 5'h0;
				pause_reg <= 16'h0;
				q_reg     <= 12'h0;
				ac_reg    <= 1'b0;
				mii_tx_enable_o[p] <= 1'b0;
				tx_done_o[p]       <= 1'b0;
				tx_abort_o[p]      <= 1'b0;
				pause_xoff_o[p]    <= 1'b0;
				pause_xon_o[p]     <= 1'b0;
			end else begin
				bcnt_reg  <= bcnt_next;
				bc_reg    <= bc_next;
				fc_reg    <= fc_next;
				dst_reg   <= dst_next;
				st_reg    <= st_next;
				cnt_reg   <= cnt_next;
				gap_reg   <= gap_next;
				bo_reg    <= bo_next;
				att_reg   <= att_next;
				pause_reg <= pause_next;
				q_reg     <= q_next;
				ac_reg    <= ac_next;
				mii_tx_enable_o[p] <= en_next;
				tx_done_o[p]       <= done_next;
				tx_abort_o[p]      <= abort_next;
				pause_xoff_o[p]    <= fc_next && !fc_reg;
				pause_xon_o[p]     <= !fc_next && fc_reg;
			end
		end
		assign bp_active_o[p] = (st_reg == switch_core_pkg::TX_BP_ON) ||
		                        (st_reg == switch_core_pkg::TX_BP_OFF);
		assign fc_act[p] = fc_reg;
		assign bcnt_all[p] = bcnt_reg;
		assign lim_all[p]  = lim;
	end
	always_comb begin
		buf_total = 11'h0;
		for (int i = 0; i < 9; i++)
			buf_total = buf_total + 11'(bcnt_all[i]);
	end
endmodule
`default_nettype wire

// >>> design/switch_core_pkg.sv
/*
 * Shared constants for the switch core: table entry layout, frame limits,
 * MAC timing counts, buffer budgets, register map and state types.
 * Assumes a single 25 MHz core clock.
 */
package switch_core_pkg;
	localparam int unsigned CLK_HZ    = 25_000_000;
	localparam int unsigned CLK_NS    = 40;
	localparam int unsigned PORTS     = 9;
	localparam int unsigned PORT_W    = 4;
	localparam int unsigned TBL_DEPTH = 1024;
	localparam int unsigned IDX_W     = 10;
	localparam int unsigned MAC_W     = 48;
	// Table entry layout
	localparam int unsigned ENT_MAC_LSB   = 0;
	localparam int unsigned ENT_PORT_LSB  = 48;
	localparam int unsigned ENT_STAMP_LSB = 52;
	localparam int unsigned ENT_VALID_BIT = 54;
	localparam int unsigned ENT_W         = 55;
	// Aging: 2-bit epoch stamps, epoch is half the aging period
	localparam longint unsigned AGE_S = 300;
	localparam longint unsigned AGE_EPOCH_CYCLES = AGE_S * CLK_HZ / 2;
	// Frame length limits in bytes
	localparam logic [10:0] MIN_LEN      = 11'd64;
	localparam logic [10:0] MAX_LEN      = 11'd1518;
	localparam logic [10:0] MAX_LEN_VLAN = 11'd1522;
	localparam logic [10:0] MAX_LEN_LONG = 11'd1536;
	// MAC timing at 100 Mb/s, gap and slot times ten at 10 Mb/s
	localparam int unsigned BIT_NS_100  = 10;
	localparam int unsigned SPEED_RATIO = 10;
	localparam int unsigned IPG_BITS    = 96;
	localparam int unsigned SLOT_BITS   = 512;
	localparam int unsigned BP_ON_BITS  = 4096;
	localparam int unsigned BP_OFF_BITS = 64;
	localparam logic [11:0] IPG_CYC  = 12'((IPG_BITS * BIT_NS_100 + CLK_NS - 1) / CLK_NS);
	localparam logic [11:0] SLOT_CYC = 12'((SLOT_BITS * BIT_NS_100 + CLK_NS - 1) / CLK_NS);
	localparam logic [11:0] BP_ON_CYC  = 12'(BP_ON_BITS * BIT_NS_100 / CLK_NS);
	localparam logic [11:0] BP_OFF_CYC = 12'(BP_OFF_BITS * BIT_NS_100 / CLK_NS);
	localparam logic [4:0]  ATTEMPT_LAST  = 5'd15;
	localparam logic [4:0]  BACKOFF_LIMIT = 5'd10;
	localparam logic [4:0]  AGGR_LIMIT    = 5'd3;
	// Buffers of 128 bytes
	localparam logic [10:0] BUF_TOTAL = 11'd1024;
	localparam logic [9:0]  BUF_FIXED = 10'd113;
	localparam logic [9:0]  BUF_ADAPT = 10'd512;
	localparam logic [9:0]  FC_HI     = 10'd8;
	localparam logic [9:0]  FC_LO     = 10'd32;
	// Broadcast storm: 5 percent of 100 Mb/s over the window, 672 bits per frame
	localparam int unsigned STORM_MS     = 10;
	localparam int unsigned STORM_CYCLES = CLK_HZ / 1000 * STORM_MS;
	localparam logic [7:0]  STORM_LIMIT  = 8'(100_000_000 / 20 / 1000 * STORM_MS / 672);
	// Register map
	localparam logic [31:0] REG_CTRL   = 32'h0000_0000;
	localparam logic [31:0] REG_STATUS = 32'h0000_0004;
	localparam int unsigned CTRL_STORM  = 0;
	localparam int unsigned CTRL_LONG   = 1;
	localparam int unsigned CTRL_DROP16 = 2;
	localparam int unsigned CTRL_AGGR   = 3;
	localparam int unsigned CTRL_BP     = 4;
	localparam logic [4:0]  CTRL_RST    = 5'h15;
	localparam int unsigned STAT_AGE_BIT   = 16;
	localparam int unsigned STAT_BMODE_BIT = 17;
	localparam int unsigned STAT_FC_LSB    = 20;
	typedef enum logic [1:0] {LK_IDLE, LK_SCAN, LK_WRITE} lk_state_type;
	typedef enum logic [2:0] {TX_IDLE, TX_SEND, TX_WAIT, TX_BP_ON, TX_BP_OFF} tx_state_type;
endpackage

// >>> dv/phy_model.sv
/* PHY model: carrier sense echoes the port's own transmit.
   Assumes the core clock. */
`timescale 1ns/1ps
`default_nettype none
module phy_model (
	input  wire logic clk_i,
	input  wire logic tx_en_i,
	output logic      crs_o
);
	always_ff @(posedge clk_i)
		crs_o <= tx_en_i;
endmodule
`default_nettype wire

// >>> dv/switch_core_lookup_mac_assertions.sv
/* Port checks for the switch core.
   Assumes it is bound at the core top and sees its ports. */
`timescale 1ns/1ps
`default_nettype none
module sw_chk (
	input wire logic        clk_i, rst_i, cyc_i, stb_i, ack_o, frm_valid_i, frm_ready_o,
	input wire logic        frm_err_i, frm_pause_i, fwd_valid_o, fwd_discard_o, rxq_full_i,
	input wire logic [3:0]  frm_port_i,
	input wire logic [10:0] frm_len_i,
	input wire logic [8:0]  fwd_mask_o, pause_xoff_o, mii_tx_enable_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [3:0] port_q;
	sequence take_s;
		frm_valid_i && frm_ready_o;
	endsequence
	always_ff @(posedge clk_i)
		if (frm_valid_i && frm_ready_o)
			port_q <= frm_port_i;
	ack_pulse_a:
		assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o) else $error("ack");
	bad_drop_a:
		assert property (take_s ##0 frm_err_i |=> fwd_discard_o) else $error("bad");
	pause_drop_a:
		assert property (take_s ##0 frm_pause_i |=> fwd_discard_o) else $error("pause");
	runt_drop_a:
		assert property (take_s ##0 frm_len_i < 11'd64 |=> fwd_discard_o) else $error("runt");
	store_fwd_a:
		assert property (take_s |=> !fwd_valid_o [*8]) else $error("early");
	no_echo_a:
		assert property (fwd_valid_o |-> !fwd_mask_o[port_q]) else $error("echo");
	tx_gap_a:
		assert property ($fell(mii_tx_enable_o[0]) |=> !mii_tx_enable_o[0] [*8])
			else $error("gap");
	xoff_a:
		assert property ($rose(rxq_full_i) |-> ##[1:6] pause_xoff_o != 9'h000)
			else $error("xoff");
endmodule
bind switch_core_lookup_mac sw_chk u_chk (.*);
`default_nettype wire

// >>> dv/testbench.sv
/* Bench: bus, descriptor and MAC stimulus with a queue scoreboard.
   Assumes the checker and PHY model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
	$display("[ERR] %0t got %h", $time, a); end end
module testbench;
	logic        clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0, ack_o, frm_ready_o;
	logic        frm_valid_i = 0, frm_err_i = 0, frm_vlan_i = 0, frm_pause_i = 0;
	logic        rxq_full_i = 0, aging_strap_i = 1, buffer_mode_strap_i = 0;
	logic        fwd_valid_o, fwd_discard_o;
	logic [31:0] adr_i = 0, dat_i = 0, dat_o, r;
	logic [3:0]  sel_i = 4'hf, frm_port_i = 0;
	logic [47:0] frm_sa_i = 0, frm_da_i = 0;
	logic [10:0] frm_len_i = 0;
	logic [15:0] frm_pause_time_i = 0;
	logic [8:0]  fwd_mask_o, buf_grant_o, pause_xoff_o, pause_xon_o, mii_tx_enable_o;
	logic [8:0]  tx_done_o, tx_abort_o, bp_active_o, full_duplex_i = '1;
	wire  [8:0]  mii_carrier_sense_i;
	logic [8:0]  tx_frame_req_i = 0, tx_last_i = 0, mii_col_i = 0, buf_alloc_i = 0;
	logic [8:0]  buf_free_i = 0, speed_10_i = 0, tx_ctrl_req_i = 0;
	logic [9:0]  q[$];
	int          fail_count = 0, tests_run = 0, n, g;
	always #20 clk_i = ~clk_i;
	switch_core_lookup_mac #(.AGE_EPOCH_CYCLES(50), .STORM_CYCLES(1000)) DUT (.*);
	phy_model u_phy (.clk_i, .tx_en_i(mii_tx_enable_o[0]), .crs_o(mii_carrier_sense_i[0]));
	assign mii_carrier_sense_i[8:1] = '0;
	always @(posedge clk_i)
		if (!rst_i && (fwd_valid_o | fwd_discard_o) === 1'b1)
			`CHK({fwd_valid_o, fwd_mask_o & {9{fwd_valid_o}}}, q.pop_front())
	task final_report();
		$display("run %0d failed %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task hang(input int lim);
		if (n >= lim) begin
			fail_count++;
			$display("[ERR] %0t timeout", $time);
			final_report();
		end
	endtask
	task wb(input logic [31:0] a, input logic w, input logic [31:0] d);
		{adr_i, we_i, dat_i, cyc_i, stb_i} <= {a, w, d, 2'b11};
		n = 0;
		do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 20);
		r = dat_o;
		{cyc_i, stb_i} <= 2'b00;
		hang(20);
		@(posedge clk_i);
	endtask
	task send(input logic [3:0] p, input logic [47:0] da, input logic [10:0] l,
		input logic e, input logic ps, input logic [9:0] x);
		n = 0;
		do @(negedge clk_i); while (frm_ready_o !== 1'b1 && ++n < 2000);
		hang(2000);
		@(posedge clk_i);
		q.push_back(x);
		{frm_port_i, frm_da_i, frm_len_i, frm_err_i, frm_pause_i} <= {p, da, l, e, ps};
		{frm_sa_i, frm_pause_time_i} <= {48'({$urandom, $urandom}) & 48'hfeff_ffff_ffff,
			16'($urandom)};
		frm_vlan_i <= 1'($urandom);
		frm_valid_i <= 1;
		@(posedge clk_i);
		frm_valid_i <= 0;
	endtask
	initial begin
		n = $urandom(32'hdb0100b2);
		repeat (3) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		wb(32'h0, 0, 0);
		`CHK(r[4:0], 5'h15)
		wb(32'h4, 0, 0);
		`CHK(r[17:16], 2'b01)
		wb(32'h8, 1, '1);
		wb(32'h8, 0, 0);
		`CHK(r, 32'h0)
		$display("regs end");
		send(1, '1, 64, 1, 0, 0);
		send(2, '1, 64, 0, 1, 0);
		send(3, '1, 63, 0, 0, 0);
		send(4, '1, 1536, 0, 0, 0);
		for (int p = 0; p < 9; p += 4)
			send(4'(p), 48'({$urandom, $urandom}) | 48'h0100_0000_0000, 1518, 0, 0,
				{1'b1, 9'h1ff ^ (9'h001 << p)});
		wb(32'h0, 1, 32'h17);
		send(5, '1, 1536, 0, 0, 10'h3df);
		n = 0;
		do @(posedge clk_i); while (q.size() != 0 && ++n < 2000);
		hang(2000);
		$display("frames end");
		tx_frame_req_i <= 9'h001;
		repeat (2) begin
			n = 0;
			do @(posedge clk_i); while (mii_tx_enable_o[0] !== 1'b1 && ++n < 300);
			hang(300);
			g = n;
			repeat (10) @(posedge clk_i);
			tx_last_i <= 9'h001;
			@(posedge clk_i);
			tx_last_i <= 9'h000;
			@(posedge clk_i);
			`CHK(tx_done_o, 9'h001)
		end
		tx_frame_req_i <= 9'h000;
		`CHK(g >= 24, 1'b1)
		buf_alloc_i <= 9'h1ff;
		@(posedge clk_i);
		`CHK(buf_grant_o, 9'h1ff)
		buf_alloc_i <= 9'h001;
		repeat (114) @(posedge clk_i);
		`CHK(buf_grant_o[0], 1'b0)
		buf_alloc_i <= 9'h000;
		rxq_full_i <= 1;
		repeat (2) @(posedge clk_i);
		`CHK(pause_xoff_o, 9'h1ff)
		repeat (6) @(posedge clk_i);
		wb(32'h4, 0, 0);
		`CHK(r[28:20], 9'h1ff)
		rxq_full_i <= 0;
		repeat (2) @(posedge clk_i);
		`CHK(pause_xon_o, 9'h1ff)
		repeat (60) @(posedge clk_i);
		$display("mac end");
		final_report();
	end
endmodule
`default_nettype wire
